// *** hdl/ssm_defs.svh ***
// Timing counts and tie-off values for the sleep-mode controller
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH
`define SSM_CLK_PERIOD_NS  50
`define SSM_ENTRY_CYCLES   2
`define SSM_RECOVER_CYCLES 2
`define SSM_CNT_W          2
`define SSM_CNT_ZERO       2'h0
`define SSM_BURST_RST      1'h1
`define SSM_TIE_PROC_ADS   1'h1
`define SSM_TIE_CTRL_ADS   1'h0
`define SSM_TIE_ADV        1'h1
`define SSM_TIE_CE_HIGH    1'h1
`endif

// *** hdl/ssm_pkg.sv ***
// Types for the sleep-mode controller
package ssm_pkg;
    typedef enum logic [1:0] {
        SSM_AWAKE,
        SSM_ENTERING,
        SSM_ASLEEP,
        SSM_RECOVERING
    } ssm_mode_e;

    // Access controls as presented at the pins, active high here
    typedef struct packed {
        logic proc_strobe;
        logic ctrl_strobe;
        logic advance;
        logic chip_en_low;
        logic chip_en_high;
        logic write;
    } ssm_ctrl_s;

    typedef struct packed {
        ssm_mode_e  mode;
        logic [1:0] cnt;
        logic       sel;
        logic       burst;
        logic       rd;
        logic       wr;
    } ssm_state_s;

    typedef struct packed {
        logic meta;
        logic sync;
    } ssm_sync_s;
endpackage

// *** hdl/ssm_sleep_ctrl.sv ***
// Sleep-mode controller: deselect, clock gating and access gating
// Notes on behaviour
// RULE1 - Sleep request puts memory into lowest power
// RULE2 - Sleep self-deselects and stays deselected
// RULE3 - Internal clock gated off while asleep
// RULE4 - Asleep: no selection, no read or write
// RULE5 - Host starts no access two cycles before sleep
// RULE6 - Host holds strobes and writes off around sleep
// RULE7 - Host distrusts read data during sleep entry
// RULE8 - Host never sleeps from stopped clock
// RULE9 - Host keeps normal timing around sleep
// RULE10 - Non-burst tie-off disables the burst counter
// RULE11 - Burst order pin tied firmly when unused
// RULE12 - Entry and recovery each take two cycles
// RULE13 - Sleep request synchronised before use
`timescale 1ns/1ps
`default_nettype none
`include "ssm_defs.svh"
module ssm_sleep_ctrl
    import ssm_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst,
    input  wire logic      sleep_request,
    input  wire ssm_ctrl_s ctrl_in,
    output logic           core_clk_en,
    output logic           access_allow,
    output logic           chip_selected,
    output logic           burst_enable,
    output logic           read_fire,
    output logic           write_fire,
    output logic           asleep,
    output logic           data_unreliable
);
    localparam logic [1:0] ENTRY_LAST =
        2'(`SSM_ENTRY_CYCLES - 1);
    localparam logic [1:0] RECOVER_LAST =
        2'(`SSM_RECOVER_CYCLES - 1);

    ssm_state_s st_q;
    ssm_state_s st_d;
    logic       req_sync;

    // Pin is not clock-registered; sample it through two flops
    ssm_sync u_sync ( // [RULE13]
        .mclk (mclk),
        .rst  (rst),
        .din  (sleep_request),
        .dout (req_sync)
    );

    // True when the pins match the non-burst tie-off
    function automatic logic is_nonburst(input ssm_ctrl_s c);
        is_nonburst = (c.proc_strobe  == `SSM_TIE_PROC_ADS) &&
                      (c.ctrl_strobe  == `SSM_TIE_CTRL_ADS) &&
                      (c.advance      == `SSM_TIE_ADV) &&
                      (c.chip_en_high == `SSM_TIE_CE_HIGH);
    endfunction

    always_comb begin
        st_d = st_q;
        unique case (st_q.mode)
            SSM_AWAKE: begin
                if (req_sync) begin
                    st_d.mode = SSM_ENTERING;
                    st_d.cnt  = `SSM_CNT_ZERO;
                end
            end
            SSM_ENTERING: begin
                // Fixed entry length, even if request drops mid-way
                if (st_q.cnt == ENTRY_LAST) begin // [RULE12]
                    st_d.mode = SSM_ASLEEP; // [RULE1]
                    st_d.cnt  = `SSM_CNT_ZERO;
                end else begin
                    st_d.cnt = 2'(st_q.cnt + 2'h1);
                end
            end
            SSM_ASLEEP: begin
                if (!req_sync) begin
                    st_d.mode = SSM_RECOVERING;
                    st_d.cnt  = `SSM_CNT_ZERO;
                end
            end
            SSM_RECOVERING: begin
                if (req_sync) begin
                    st_d.mode = SSM_ENTERING;
                    st_d.cnt  = `SSM_CNT_ZERO;
                end else if (st_q.cnt == RECOVER_LAST) begin // [RULE12]
                    st_d.mode = SSM_AWAKE;
                    st_d.cnt  = `SSM_CNT_ZERO;
                end else begin
                    st_d.cnt = 2'(st_q.cnt + 2'h1);
                end
            end
        endcase
        // Access pulses last one cycle unless a strobe is taken
        st_d.rd = 1'h0;
        st_d.wr = 1'h0;
        if (st_q.mode == SSM_ASLEEP) begin
            st_d.sel = 1'h0; // [RULE2] [RULE4]
        end else if (access_allow &&
                     (ctrl_in.proc_strobe || ctrl_in.ctrl_strobe)) begin
            st_d.sel = ctrl_in.chip_en_low && ctrl_in.chip_en_high;
            st_d.rd  = st_d.sel && !ctrl_in.write;
            st_d.wr  = st_d.sel && ctrl_in.write;
        end else if (!access_allow) begin
            // Entry and recovery also deselect; writes may corrupt
            st_d.sel = 1'h0;
        end
        st_d.burst = !is_nonburst(ctrl_in); // [RULE10]
    end

    // Host keeps strobes idle outside AWAKE; we gate anyway
    assign access_allow = (st_q.mode == SSM_AWAKE); // [RULE6]

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '{mode:  SSM_AWAKE,
                      cnt:   `SSM_CNT_ZERO,
                      sel:   1'h0,
                      burst: `SSM_BURST_RST,
                      rd:    1'h0,
                      wr:    1'h0};
        end else begin
            st_q <= st_d;
        end
    end

    // Clock buffer disconnected only in full sleep
    assign core_clk_en     = (st_q.mode != SSM_ASLEEP); // [RULE3]
    assign asleep          = (st_q.mode == SSM_ASLEEP);
    assign chip_selected   = st_q.sel;
    assign burst_enable    = st_q.burst;
    assign read_fire       = st_q.rd;
    assign write_fire      = st_q.wr;
    assign data_unreliable = (st_q.mode == SSM_ENTERING);

    entry_len_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_AWAKE && req_sync) |=>
        (st_q.mode == SSM_ENTERING) ##2 (st_q.mode == SSM_ASLEEP))
        else $error("sleep entry not two cycles"); // [RULE12]
    recover_len_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_ASLEEP && !req_sync) ##1 (!req_sync)[*2] |=>
        (st_q.mode == SSM_AWAKE))
        else $error("recovery not two cycles"); // [RULE12]
    sleep_desel_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_ASLEEP) ##1 (st_q.mode == SSM_ASLEEP)
        |-> !chip_selected)
        else $error("selected while asleep"); // [RULE2]
    sleep_noop_a: assert property (@(posedge mclk) disable iff (rst)
        $past(st_q.mode) == SSM_ASLEEP |-> !read_fire && !write_fire)
        else $error("access while asleep"); // [RULE4]
    clk_gate_a: assert property (@(posedge mclk) disable iff (rst)
        asleep == !core_clk_en)
        else $error("clock gate mismatch"); // [RULE3]
    sync_delay_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(sleep_request) ##1 sleep_request[*2] |->
        req_sync)
        else $error("request sync latency wrong"); // [RULE13]
    nonburst_a: assert property (@(posedge mclk) disable iff (rst)
        is_nonburst(ctrl_in) |=> !burst_enable)
        else $error("burst counter not disabled"); // [RULE10]
    reach_sleep_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(req_sync) && st_q.mode == SSM_AWAKE |-> ##[3:3] asleep)
        else $error("sleep not reached"); // [RULE1]

    // Entry window: data suspect, no access taken
    entry_unrel_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_ENTERING) |-> data_unreliable && !access_allow)
        else $error("entry window not flagged"); // [RULE12]

    entry_desel_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_ENTERING && $past(st_q.mode) == SSM_ENTERING)
        |-> !chip_selected) else $error("selected during entry"); // [RULE2]

    gate_fire_a: assert property (@(posedge mclk) disable iff (rst)
        ($past(st_q.mode) != SSM_AWAKE) |-> !read_fire && !write_fire)
        else $error("access outside awake"); // [RULE6]

    fire_select_a: assert property (@(posedge mclk) disable iff (rst)
        (read_fire || write_fire) |-> chip_selected)
        else $error("access without select"); // [RULE4]

    fire_excl_a: assert property (@(posedge mclk) disable iff (rst)
        !(read_fire && write_fire))
        else $error("read and write together"); // [RULE4]

    asleep_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        asleep |-> !chip_selected && !read_fire && !write_fire)
        else $error("activity while asleep"); // [RULE2]

    // Recovery runs the clock again but still refuses access
    recover_clk_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_RECOVERING) |-> core_clk_en && !access_allow)
        else $error("recovery gating wrong"); // [RULE3]

    restart_entry_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_RECOVERING && req_sync) |=>
        (st_q.mode == SSM_ENTERING)) else $error("no restart"); // [RULE12]

    sleep_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (asleep && req_sync) |=> asleep)
        else $error("left sleep while requested"); // [RULE1]

    entry_fixed_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_ENTERING && st_q.cnt == ENTRY_LAST) |=> asleep)
        else $error("entry overran"); // [RULE12]

    wake_allow_a: assert property (@(posedge mclk) disable iff (rst)
        (st_q.mode == SSM_RECOVERING && st_q.cnt == RECOVER_LAST &&
        !req_sync) |=> access_allow) else $error("no wake"); // [RULE12]

    // Burst counter runs again once the tie-off pattern is gone
    burst_tie_a: assert property (@(posedge mclk) disable iff (rst)
        !is_nonburst(ctrl_in) |=> burst_enable)
        else $error("burst counter stuck off"); // [RULE10]

    sync_fall_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(sleep_request) ##1 (!sleep_request)[*2] |-> !req_sync)
        else $error("request release latency wrong"); // [RULE13]
endmodule
`default_nettype wire

// *** hdl/ssm_sync.sv ***
// Two-flop synchroniser for the asynchronous sleep request
`timescale 1ns/1ps
`default_nettype none
module ssm_sync
    import ssm_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    ssm_sync_s s_q;
    ssm_sync_s s_d;

    // Only the second stage is read outside this module
    always_comb begin
        s_d.meta = din;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '{meta: 1'h0, sync: 1'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.sync;
endmodule
`default_nettype wire

// *** testbench/ssm_host.sv ***
// Host model driving the sleep pin and access controls
`timescale 1ns/1ps
`default_nettype none
module ssm_host
    import ssm_pkg::*;
(
    input  wire logic mclk,
    output logic      sleep_request,
    output ssm_ctrl_s ctrl_in
);
    // Clock runs from time zero and never stops
    initial begin
        sleep_request = 1'h0;
        ctrl_in = '0;
    end
    // One cycle of controls, entered and left just after an edge
    task automatic drive(input ssm_ctrl_s v);
        ctrl_in = v;
        @(posedge mclk);
        #1;
    endtask
    task automatic access(input logic wr);
        drive({1'h1, 1'h0, 1'h0, 1'h1, 1'h1, wr});
    endtask
    // Quiet two cycles before the pin rises
    task automatic enter_sleep;
        drive('0);
        drive('0);
        sleep_request = 1'h1;
    endtask
    // No strobe or write during recovery
    task automatic leave_sleep;
        ctrl_in = '0;
        sleep_request = 1'h0;
    endtask
endmodule
`default_nettype wire

// *** testbench/ssm_sleep_ctrl_test.sv ***
// Self-checking bench for the sleep-mode controller
`timescale 1ns/1ps
`default_nettype none
module ssm_sleep_ctrl_test
    import ssm_pkg::*;
;
    logic       mclk = 1'h0;
    logic       rst = 1'h1;
    logic       sleep_request, core_clk_en, access_allow, chip_selected;
    logic       burst_enable, read_fire, write_fire, asleep, data_unreliable;
    ssm_ctrl_s  ctrl_in;
    logic [1:0] fire_q[$];
    integer     seed = 18094;
    int         miscompares = 0;
    int         n_tests = 0;
    int         n;
    logic       wr;

    always #25 mclk = ~mclk;

    ssm_host host (.mclk(mclk), .sleep_request(sleep_request),
                   .ctrl_in(ctrl_in));
    ssm_sleep_ctrl DUT (.mclk(mclk), .rst(rst),
        .sleep_request(sleep_request), .ctrl_in(ctrl_in),
        .core_clk_en(core_clk_en), .access_allow(access_allow),
        .chip_selected(chip_selected), .burst_enable(burst_enable),
        .read_fire(read_fire), .write_fire(write_fire),
        .asleep(asleep), .data_unreliable(data_unreliable));

    task automatic chk(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Every fire pulse must match the oldest expected access
    always @(posedge mclk) begin
        #2;
        if (!rst && (read_fire !== 1'h0 || write_fire !== 1'h0)) begin
            n_tests++;
            if (fire_q.size() == 0 ||
                fire_q.pop_front() !== {write_fire, read_fire}) begin
                miscompares++;
                $display("BAD fire seen %b%b", write_fire, read_fire);
            end
        end
    end

    task automatic accesses(input int cnt);
        repeat (cnt) begin
            wr = 1'($random(seed));
            fire_q.push_back({wr, ~wr});
            host.access(wr);
        end
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        #1 rst = 1'h0;
        chk("clk_en", 1'h1, core_clk_en);
        chk("burst", 1'h1, burst_enable);
        accesses(4);
        host.drive(6'h2a);
        chk("burst", 1'h0, burst_enable);
        host.drive('0);
        chk("burst", 1'h1, burst_enable);
        host.enter_sleep();
        n = 0;
        while (asleep !== 1'h1 && n < 20) begin
            @(posedge mclk);
            #1 n++;
            if (n == 3) chk("unreliable", 1'h1, data_unreliable);
            if (n == 3) chk("allow", 1'h0, access_allow);
        end
        chk("entry", 1'h1, n == 5);
        chk("clk_en", 1'h0, core_clk_en);
        repeat (8) begin
            // Random strobes while asleep must not fire
            host.drive(6'($random(seed)));
            chk("select", 1'h0, chip_selected);
        end
        // Request back mid-recovery must restart a full entry
        host.leave_sleep();
        host.drive('0);
        host.drive('0);
        host.sleep_request = 1'h1;
        repeat (3) host.drive('0);
        chk("restart", 1'h1, data_unreliable);
        chk("allow", 1'h0, access_allow);
        repeat (2) host.drive('0);
        chk("asleep", 1'h1, asleep);
        host.leave_sleep();
        n = 0;
        while (access_allow !== 1'h1 && n < 20) begin
            @(posedge mclk);
            #1 n++;
            if (n == 3) chk("asleep", 1'h0, asleep);
        end
        chk("recover", 1'h1, n == 5);
        chk("clk_en", 1'h1, core_clk_en);
        accesses(3);
        host.drive('0);
        host.drive('0);
        chk("drained", 1'h1, fire_q.size() == 0);
        report_and_stop();
    end

    initial begin
        #(400 * 50);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
